/* File: core/tws_slave.sv */
// Purpose: slave side of a two-wire serial memory port, 2K x 8
// Assumes: link_clk_i oversamples the bus lines well above the bus rate
// Notes: bus logic runs on link_clk_i; busy_o is crossed to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "tws_cfg.svh"
module tws_slave #(
   parameter logic [3:0] TYPE_CODE = 4'h5   // device type code, value arbitrary
) (
   input wire logic clk_i,          // system clock, 40 MHz
   input wire logic arst_n_i,       // async reset, active low
   input wire logic link_clk_i,     // link-side sampling clock
   input wire logic scl_i,          // serial clock pin
   input wire logic sda_i,          // serial data pin level
   output logic sda_o,              // serial data drive value
   output logic sda_oe_o,           // serial data drive enable
   input wire logic wp_i,           // write protect pin
   input wire logic low_supply_i,   // low supply indication
   output logic busy_o              // transfer in progress, clk_i domain
);
   tws_mem_if mem_if ();

   logic [1:0] pin_sync_q [`TWS_NPIN];
   logic [`TWS_NPIN-1:0] pin_raw;
   logic scl_s, sda_s, wp_s, lowv_s;
   logic scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_ev, stop_ev, byte_end, type_ok, prot, load_rd;
   tws_pkg::tws_state_type state_q, state_d;
   logic [3:0] cnt_q;
   logic [7:0] shift_q, tx_q;
   logic [2:0] page_q;
   logic [10:0] addr_q;
   logic rw_q, oe_q, sda_q, busy_q;
   logic [1:0] busy_sync_q;

   function automatic logic is_protected(input logic [10:0] a, input logic wp);
      is_protected = wp & a[`TWS_TOP_BIT];
   endfunction

   assign pin_raw = {low_supply_i, wp_i, sda_i, scl_i};

   // two-stage synchronisers on every pin; only stage two is read
   generate
      for (genvar k = 0; k < `TWS_NPIN; k++) begin : g_sync
         always_ff @(posedge link_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               pin_sync_q[k] <= 2'h3;
            end else begin
               pin_sync_q[k] <= {pin_sync_q[k][0], pin_raw[k]};
            end
         end
      end
   endgenerate

   assign scl_s = pin_sync_q[`TWS_PIN_SCL][1];
   assign sda_s = pin_sync_q[`TWS_PIN_SDA][1];
   assign wp_s = pin_sync_q[`TWS_PIN_WP][1];
   assign lowv_s = pin_sync_q[`TWS_PIN_LOWV][1];

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // the master alone makes scl; we only watch its edges
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign byte_end = scl_fall & (cnt_q == `TWS_BYTE_END);
   assign type_ok = shift_q[`TWS_TYPE_HI:`TWS_TYPE_LO] == TYPE_CODE;
   assign prot = is_protected(addr_q, wp_s);

   always_comb begin
      state_d = state_q;
      if (lowv_s) begin
         state_d = tws_pkg::TWS_IDLE;
      end else if (start_ev) begin
         state_d = tws_pkg::TWS_DEV;
      end else if (stop_ev) begin
         state_d = tws_pkg::TWS_IDLE;
      end else begin
         case (state_q)
            tws_pkg::TWS_IDLE: begin
               state_d = tws_pkg::TWS_IDLE;
            end
            tws_pkg::TWS_DEV: begin
               if (byte_end) begin
                  state_d = type_ok ? tws_pkg::TWS_DACK : tws_pkg::TWS_IDLE;
               end
            end
            tws_pkg::TWS_DACK: begin
               if (scl_fall) begin
                  state_d = rw_q ? tws_pkg::TWS_RDAT : tws_pkg::TWS_WADR;
               end
            end
            tws_pkg::TWS_WADR: begin
               if (byte_end) begin
                  state_d = tws_pkg::TWS_WACK;
               end
            end
            tws_pkg::TWS_WACK: begin
               if (scl_fall) begin
                  state_d = tws_pkg::TWS_WDAT;
               end
            end
            tws_pkg::TWS_WDAT: begin
               if (byte_end) begin
                  state_d = prot ? tws_pkg::TWS_IDLE : tws_pkg::TWS_WDACK;
               end
            end
            tws_pkg::TWS_WDACK: begin
               if (scl_fall) begin
                  state_d = tws_pkg::TWS_WDAT;
               end
            end
            tws_pkg::TWS_RDAT: begin
               if (byte_end) begin
                  state_d = tws_pkg::TWS_RACK;
               end
            end
            tws_pkg::TWS_RACK: begin
               // master nack ends the read; its ack asks for the next byte
               if (scl_rise && sda_s) begin
                  state_d = tws_pkg::TWS_IDLE;
               end else if (scl_fall) begin
                  state_d = tws_pkg::TWS_RDAT;
               end
            end
            default: begin
               state_d = tws_pkg::TWS_IDLE;
            end
         endcase
      end
   end

   assign load_rd = (state_q != tws_pkg::TWS_RDAT) && (state_d == tws_pkg::TWS_RDAT);

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= tws_pkg::TWS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // bit counter: receive states count rising edges, read counts driven bits
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 4'h0;
      end else if (lowv_s || start_ev || stop_ev) begin
         cnt_q <= 4'h0;
      end else if (load_rd) begin
         cnt_q <= `TWS_CNT_ONE;
      end else if (scl_rise && (state_q == tws_pkg::TWS_DEV || state_q == tws_pkg::TWS_WADR ||
                                state_q == tws_pkg::TWS_WDAT)) begin
         cnt_q <= cnt_q + `TWS_CNT_ONE;
      end else if (scl_fall && state_q == tws_pkg::TWS_RDAT && cnt_q != `TWS_BYTE_END) begin
         cnt_q <= cnt_q + `TWS_CNT_ONE;
      end else if (scl_fall && state_q != tws_pkg::TWS_RDAT && state_q != tws_pkg::TWS_DEV &&
                   state_q != tws_pkg::TWS_WADR && state_q != tws_pkg::TWS_WDAT) begin
         cnt_q <= 4'h0;
      end
   end

   // receive shifter, msb arrives first
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_q <= 8'h00;
      end else if (scl_rise && (state_q == tws_pkg::TWS_DEV || state_q == tws_pkg::TWS_WADR ||
                                state_q == tws_pkg::TWS_WDAT)) begin
         shift_q <= {shift_q[6:0], sda_s};
      end
   end

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rw_q <= 1'b0;
         page_q <= 3'h0;
      end else if (state_q == tws_pkg::TWS_DEV && byte_end) begin
         rw_q <= shift_q[`TWS_RW_BIT];
         page_q <= shift_q[`TWS_PAGE_HI:`TWS_PAGE_LO];
      end
   end

   // address latch survives a restart, which is what makes random reads work
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_q <= 11'h000;
      end else if (state_q == tws_pkg::TWS_DEV && state_d == tws_pkg::TWS_DACK &&
                   shift_q[`TWS_RW_BIT]) begin
         addr_q[10:8] <= shift_q[`TWS_PAGE_HI:`TWS_PAGE_LO];
      end else if (state_q == tws_pkg::TWS_WADR && state_d == tws_pkg::TWS_WACK) begin
         addr_q <= {page_q, shift_q};
      end else if ((state_q == tws_pkg::TWS_WDAT && state_d == tws_pkg::TWS_WDACK) || load_rd) begin
         addr_q <= addr_q + `TWS_ADDR_ONE;   // wraps after the last location
      end
   end

   // read transmit register
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_q <= 8'h00;
      end else if (load_rd) begin
         tx_q <= {mem_if.rdata[6:0], 1'b0};
      end else if (scl_fall && state_q == tws_pkg::TWS_RDAT) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // open-drain data: enable pulls low, release lets the pull-up win
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oe_q <= 1'b0;
      end else if (state_d == tws_pkg::TWS_IDLE || start_ev || stop_ev) begin
         oe_q <= 1'b0;
      end else if (load_rd) begin
         oe_q <= ~mem_if.rdata[7];
      end else if (scl_fall) begin
         case (state_q)
            tws_pkg::TWS_DEV, tws_pkg::TWS_WADR, tws_pkg::TWS_WDAT: begin
               oe_q <= byte_end;
            end
            tws_pkg::TWS_RDAT: begin
               oe_q <= (cnt_q != `TWS_BYTE_END) & ~tx_q[7];
            end
            default: begin
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sda_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         sda_q <= 1'b0;
         busy_q <= state_d != tws_pkg::TWS_IDLE;
      end
   end

   // byte lands in the array in one cycle, so no busy period follows a write
   assign mem_if.we = (state_q == tws_pkg::TWS_WDAT) && (state_d == tws_pkg::TWS_WDACK);
   assign mem_if.addr = addr_q;
   assign mem_if.wdata = shift_q;

   tws_mem u_mem (
      .clk_i(link_clk_i),
      .arst_n_i(arst_n_i),
      .port(mem_if.mem)
   );

   // busy is a level, two flops are enough to bring it over
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_sync_q <= 2'h0;
      end else begin
         busy_sync_q <= {busy_sync_q[0], busy_q};
      end
   end

   assign busy_o = busy_sync_q[1];
   assign sda_o = sda_q;
   assign sda_oe_o = oe_q;

   default clocking cb @(posedge link_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_dev_end;
      state_q == tws_pkg::TWS_DEV && byte_end && !lowv_s;
   endsequence

   sequence s_wr_end;
      state_q == tws_pkg::TWS_WDAT && byte_end && !lowv_s && !start_ev && !stop_ev;
   endsequence

   start_restart_a: assert property (start_ev && !lowv_s |=> state_q == tws_pkg::TWS_DEV && !oe_q)
      else $error("start did not restart the transfer");
   stop_idle_a: assert property (stop_ev && !start_ev && !lowv_s |=> state_q == tws_pkg::TWS_IDLE && !oe_q)
      else $error("stop did not idle the port");
   low_supply_a: assert property (lowv_s |=> state_q == tws_pkg::TWS_IDLE && !oe_q)
      else $error("low supply did not block access");
   type_ack_a: assert property (s_dev_end and type_ok |=> oe_q && state_q == tws_pkg::TWS_DACK)
      else $error("matching slave address not acknowledged");
   type_miss_a: assert property (s_dev_end and !type_ok |=> state_q == tws_pkg::TWS_IDLE && !oe_q)
      else $error("foreign slave address acknowledged");
   wp_block_a: assert property (s_wr_end and prot |-> !mem_if.we ##1 !oe_q && $stable(addr_q))
      else $error("protected write was not blocked");
   wrap_addr_a: assert property (mem_if.we && addr_q == `TWS_ADDR_LAST |=> addr_q == 11'h000)
      else $error("address latch did not wrap");
   nack_abort_a: assert property (state_q == tws_pkg::TWS_RACK && scl_rise && sda_s && !start_ev
                                  |=> state_q == tws_pkg::TWS_IDLE)
      else $error("read continued after master nack");
   read_page_a: assert property (s_dev_end and type_ok and shift_q[0]
                                 |=> addr_q[10:8] == $past(shift_q[3:1]))
      else $error("read page bits not loaded");
   rd_drive_a: assert property (load_rd |=> oe_q == ~$past(mem_if.rdata[7]) ##1 !sda_o)
      else $error("read byte not driven msb first");
   write_ack_a: assert property (s_wr_end and !prot |=> oe_q && state_q == tws_pkg::TWS_WDACK)
      else $error("accepted data byte not acknowledged");
   ack_release_a: assert property (state_q == tws_pkg::TWS_WDACK && scl_fall && !lowv_s |=> !oe_q)
      else $error("data line held after acknowledge slot");
   word_load_a: assert property (state_q == tws_pkg::TWS_WADR && byte_end && !lowv_s
                                 |=> addr_q == {$past(page_q), $past(shift_q)})
      else $error("word address not latched with page bits");
   // the master needs the line free in the ninth clock to give its own answer
   rd_release_a: assert property (state_q == tws_pkg::TWS_RDAT && byte_end && !lowv_s
                                  |=> !oe_q && state_q == tws_pkg::TWS_RACK)
      else $error("read byte did not release for master acknowledge");
endmodule
`default_nettype wire

/* File: core/tws_cfg.svh */
// Purpose: constants of the two-wire memory slave port
// Assumes: included by bare name from design files
// Notes: widths and field positions of the slave address byte
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define TWS_ADDR_W 11
`define TWS_DEPTH 2048
`define TWS_BYTE_END 4'h8
`define TWS_CNT_ONE 4'h1
`define TWS_ADDR_ONE 11'h001
`define TWS_ADDR_LAST 11'h7FF
`define TWS_TOP_BIT 10
`define TWS_TYPE_HI 7
`define TWS_TYPE_LO 4
`define TWS_PAGE_HI 3
`define TWS_PAGE_LO 1
`define TWS_RW_BIT 0
`define TWS_NPIN 4
`define TWS_PIN_SCL 0
`define TWS_PIN_SDA 1
`define TWS_PIN_WP 2
`define TWS_PIN_LOWV 3
`endif

/* File: core/tws_pkg.sv */
// Purpose: types shared by the two-wire memory slave port
// Assumes: nothing
// Notes: one-hot protocol states
package tws_pkg;
   typedef enum logic [8:0] {
      TWS_IDLE  = 9'h001,
      TWS_DEV   = 9'h002,
      TWS_DACK  = 9'h004,
      TWS_WADR  = 9'h008,
      TWS_WACK  = 9'h010,
      TWS_WDAT  = 9'h020,
      TWS_WDACK = 9'h040,
      TWS_RDAT  = 9'h080,
      TWS_RACK  = 9'h100
   } tws_state_type;
endpackage

/* File: core/tws_mem_if.sv */
// Purpose: carrier between the protocol engine and the byte array
// Assumes: both ends on the link clock
// Notes: read data is registered inside the array
`timescale 1ns/100ps
`default_nettype none
interface tws_mem_if;
   logic we;
   logic [10:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport host (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: core/tws_mem.sv */
// Purpose: 2K x 8 byte array behind the slave port
// Assumes: single clock, write and read in the same cycle allowed
// Notes: read data follows the address one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "tws_cfg.svh"
module tws_mem (
   input wire logic clk_i,      // link clock
   input wire logic arst_n_i,   // async reset, active low
   tws_mem_if.mem port          // array access
);
   logic [7:0] array_q [`TWS_DEPTH];
   logic [7:0] rdata_q;

   always_ff @(posedge clk_i) begin
      if (port.we) begin
         array_q[port.addr] <= port.wdata;
      end
   end

   // data reads back whatever sits at the latch, so a fetch needs no request
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= array_q[port.addr];
      end
   end

   assign port.rdata = rdata_q;
endmodule
`default_nettype wire

/* File: dv/tws_master.sv */
// Purpose: behavioural two-wire bus master for the slave port bench
// Assumes: link clock ticks pace every bus phase
// Notes: data line is wired-AND with a pull-up, resolved in the bench
`timescale 1ns/100ps
`default_nettype none
module tws_master (
   input wire logic lclk_i,   // pacing clock
   input wire logic sda_i,    // resolved data line
   output var logic scl_o,    // serial clock, high while idle
   output var logic pull_o    // high pulls the data line low
);
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge lclk_i);
      #1;
   endtask
   // data moves only mid clock-low, away from both edges, so no false start or stop
   task automatic xfer_bit(input logic b, output logic r);
      tick(5);
      pull_o = ~b;
      tick(5);
      scl_o = 1'b1;
      tick(5);
      r = sda_i;
      tick(5);
      scl_o = 1'b0;
   endtask
   task automatic start_c;
      tick(5);
      pull_o = 1'b0;
      tick(5);
      scl_o = 1'b1;
      tick(10);
      pull_o = 1'b1;
      tick(10);
      scl_o = 1'b0;
   endtask
   task automatic stop_c;
      tick(5);
      pull_o = 1'b1;
      tick(5);
      scl_o = 1'b1;
      tick(10);
      pull_o = 1'b0;
      tick(10);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(~mack, r);
   endtask
endmodule
`default_nettype wire

/* File: dv/tws_slave_bench.sv */
// Purpose: self-checking bench for the two-wire memory slave port
// Assumes: master model paces the bus at ten link cycles per phase
// Notes: array is not reset, so every read but the one cut off by reset and the one after a master nack targets a byte written here
`timescale 1ns/100ps
`default_nettype none
module tws_slave_bench;
   localparam logic [3:0] TYPE_CODE = 4'h5; // value arbitrary
   typedef struct packed {
      logic wp;
      logic [2:0] pg;
      logic [7:0] wd;
      logic [7:0] d;
      logic ack;
      logic [7:0] exp;
   } tws_row_type;
   logic clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wp = 1'b0;
   logic lows = 1'b0;
   logic scl, pull, sda_o, sda_oe, busy;
   wire sda;
   int fails = 0;
   int checked = 0;
   tws_row_type rows [4];
   assign sda = ~(sda_oe | pull);
   always #12.5 clk_i = ~clk_i;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   tws_slave #(.TYPE_CODE(TYPE_CODE)) uut (.clk_i(clk_i), .arst_n_i(arst_n), .link_clk_i(link_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .low_supply_i(lows),
      .busy_o(busy));
   tws_master m (.lclk_i(link_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [7:0] dev(input logic [2:0] pg, input logic rw);
      return {TYPE_CODE, pg, rw};
   endfunction
   task automatic send(input logic [7:0] d, input logic ea);
      logic a;
      m.wr_byte(d, a);
      chk({7'h00, a}, {7'h00, ea});
   endtask
   task automatic readb(input logic mack, input logic [7:0] exp);
      logic [7:0] d;
      m.rd_byte(mack, d);
      chk(d, exp);
   endtask
   task automatic setaddr(input logic [2:0] pg, input logic [7:0] wd);
      m.start_c;
      send(dev(pg, 1'b0), 1'b1);
      send(wd, 1'b1);
      m.start_c;
      send(dev(pg, 1'b1), 1'b1);
   endtask
   task automatic drv(input logic w, input logic l);
      @(posedge clk_i);
      #1;
      wp = w;
      lows = l;
   endtask
   task automatic done(input string s);
      $display("test %s done, fails so far %0d", s, fails);
   endtask
   // the device may only ever pull the line low
   always @(posedge link_clk) if (sda_oe === 1'b1) chk({7'h00, sda_o}, 8'h00);
   initial begin
      #1500000;
      fails++;
      tally_and_finish;
   end
   initial begin
      logic a;
      int n;
      rows[0] = {1'b0, 3'h7, 8'hFE, 8'hA5, 1'b1, 8'hA5};
      rows[1] = {1'b1, 3'h7, 8'hFE, 8'h3C, 1'b0, 8'hA5};
      rows[2] = {1'b1, 3'h3, 8'h01, 8'h5A, 1'b1, 8'h5A};
      rows[3] = {1'b0, 3'h0, 8'h00, 8'h81, 1'b1, 8'h81};
      repeat (6) @(posedge clk_i);
      chk({6'h00, sda_oe, busy}, 8'h00);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      foreach (rows[k]) begin
         drv(rows[k].wp, 1'b0);
         m.start_c;
         send(dev(rows[k].pg, 1'b0), 1'b1);
         send(rows[k].wd, 1'b1);
         send(rows[k].d, rows[k].ack);
         m.stop_c;
         setaddr(rows[k].pg, rows[k].wd);
         readb(1'b0, rows[k].exp);
         m.stop_c;
      end
      drv(1'b0, 1'b0);
      done("table");
      m.start_c;
      send(dev(3'h7, 1'b0), 1'b1);
      send(8'hFF, 1'b1);
      send(8'h11, 1'b1);
      send(8'h22, 1'b1);
      m.stop_c;
      setaddr(3'h7, 8'hFF);
      readb(1'b1, 8'h11);
      readb(1'b0, 8'h22);
      m.stop_c;
      // latch now 0x001, so a page-3 read must hit 0x301
      m.start_c;
      send(dev(3'h3, 1'b1), 1'b1);
      readb(1'b0, 8'h5A);
      readb(1'b0, 8'hFF);
      m.stop_c;
      done("wrap and current read");
      drv(1'b1, 1'b0);
      m.start_c;
      send(dev(3'h7, 1'b0), 1'b1);
      send(8'hFE, 1'b1);
      send(8'h3C, 1'b0);
      m.start_c;
      send(dev(3'h7, 1'b1), 1'b1);
      readb(1'b0, 8'hA5);
      m.stop_c;
      drv(1'b0, 1'b0);
      m.start_c;
      send({~TYPE_CODE, 3'h0, 1'b0}, 1'b0);
      send(8'h00, 1'b0);
      m.stop_c;
      done("protect and type");
      m.start_c;
      send(dev(3'h0, 1'b0), 1'b1);
      send(8'h00, 1'b1);
      for (int i = 0; i < 4; i++) m.xfer_bit(1'b1, a);
      m.start_c;
      send(dev(3'h0, 1'b1), 1'b1);
      readb(1'b0, 8'h22);
      m.stop_c;
      m.start_c;
      send(dev(3'h0, 1'b0), 1'b1);
      chk({7'h00, busy}, 8'h01);
      m.xfer_bit(1'b0, a);
      m.stop_c;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk({7'h00, busy}, 8'h00);
      if (n == 100) tally_and_finish;
      done("restart and stop");
      drv(1'b0, 1'b1);
      m.start_c;
      send(dev(3'h0, 1'b0), 1'b0);
      m.stop_c;
      drv(1'b0, 1'b0);
      m.start_c;
      send(dev(3'h0, 1'b0), 1'b1);
      drv(1'b0, 1'b1);
      send(8'h00, 1'b0);
      drv(1'b0, 1'b0);
      m.stop_c;
      m.start_c;
      send(dev(3'h0, 1'b1), 1'b1);
      m.xfer_bit(1'b1, a);
      @(posedge clk_i);
      #1 arst_n = 1'b0;
      #5 chk({6'h00, sda_oe, busy}, 8'h00);
      m.stop_c;
      @(posedge clk_i);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      setaddr(3'h0, 8'h00);
      readb(1'b0, 8'h22);
      m.stop_c;
      done("low supply and reset");
      tally_and_finish;
   end
endmodule
`default_nettype wire
